// ==== dprr_defines.vh ====
// Purpose: Offsets, field positions and reset values for the protected
//          region register block.
// Assumes: 32-bit AXI4-Lite register bus, byte addresses.
// Notes:   Definitions only.
`ifndef DPRR_DEFINES_VH
`define DPRR_DEFINES_VH

// Register byte offsets
`define DPRR_OFF_LOW_BASE     12'h068
`define DPRR_OFF_LOW_LIMIT    12'h06c
`define DPRR_OFF_HIGH_BASE_LO 12'h070
`define DPRR_OFF_HIGH_BASE_HI 12'h074
`define DPRR_OFF_HIGH_LIMIT_LO 12'h078
`define DPRR_OFF_HIGH_LIMIT_HI 12'h07c
`define DPRR_OFF_ENABLE       12'h064
`define DPRR_OFF_CAP          12'h008

// Field positions
`define DPRR_EN_BIT           31
`define DPRR_PRS_BIT          0
`define DPRR_CAP_LOW_BIT      5
`define DPRR_CAP_HIGH_BIT     6

// Reset values
`define DPRR_RST_32           32'h0000_0000
`define DPRR_RST_64           64'h0000_0000_0000_0000

// AXI responses
`define DPRR_RESP_OKAY        2'b00
`define DPRR_RESP_SLVERR      2'b10

`endif

// ==== dprr_regs.v ====
// Purpose: Protected low/high memory region registers with AXI4-Lite
//          access and a DMA address block check.
// Assumes: Single clock aclk, synchronous active-low aresetn. Inputs are
//          synchronous to aclk; one write and one read at most in flight.
// Notes:   Registers sit in a 12-bit byte window, one 32-bit word each, two for high base and high limit.
//          Writes while protection is on are not refused here; keeping
//          them out is the duty of software. Status lags enable by one
//          clock, so a check issued right after enabling is not blocked.
//          Unmapped offsets answer SLVERR and read as zero.
//          High words above the host address width are not stored.
//
// Notes on behaviour
// - Low limit register is read-only when low region unsupported.
// - High base register is read-only when high region unsupported.
// - Low limit bits N:0 decode as all ones.
// - High base bits N:0 decode as all zeros.
// - Reserved bits N:0 read back zero after any write.
// - Equal low base and limit upper bits protect 2^(N+1) bytes.
// - Low limit below low base disables the low region.
// - Low limit is 32 bits at 06Ch, field 31:(N+1), resets zero.
// - High base is 64 bits at 070h, field 63:(N+1), resets zero.
// - High base bits at host address width and above are ignored.
// - High base may place the region above or below 4GB.
// - Status reads 0 while disabled, 1 once enabled.
// - High limit below high base disables the high region.
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "dprr_defines.vh"

module dprr_regs #(
  parameter RSVD_N        = 19,
  parameter HOST_AW       = 39,
  parameter LOW_SUPPORTED = 1,
  parameter HIGH_SUPPORTED = 1
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire [63:0] dma_addr,
  input  wire        dma_valid,
  output reg         dma_blocked
);

  // Writable masks: field above N, and below host address width for high
  localparam [63:0] FIELD_MASK = ~((64'h1 << (RSVD_N + 1)) - 64'h1);
  localparam [63:0] HAW_MASK   = (HOST_AW >= 64) ? 64'hffff_ffff_ffff_ffff
                                 : ((64'h1 << HOST_AW) - 64'h1);
  localparam [63:0] HIGH_MASK  = FIELD_MASK & HAW_MASK;
  localparam [31:0] LOW_MASK   = FIELD_MASK[31:0];
  localparam [63:0] LOW_ONES   = ~FIELD_MASK;
  // Bits N:0 are never stored, so software reads them back as zero and
  // can find N; the decoders below supply their ones or zeros instead.

  // Byte offsets of the mapped registers
  localparam [11:0] OFF_CAP      = `DPRR_OFF_CAP;
  localparam [11:0] OFF_ENABLE   = `DPRR_OFF_ENABLE;
  localparam [11:0] OFF_LOW_BASE = `DPRR_OFF_LOW_BASE;
  localparam [11:0] OFF_LOW_LIM  = `DPRR_OFF_LOW_LIMIT;
  localparam [11:0] OFF_HB_LO    = `DPRR_OFF_HIGH_BASE_LO;
  localparam [11:0] OFF_HB_HI    = `DPRR_OFF_HIGH_BASE_HI;
  localparam [11:0] OFF_HL_LO    = `DPRR_OFF_HIGH_LIMIT_LO;
  localparam [11:0] OFF_HL_HI    = `DPRR_OFF_HIGH_LIMIT_HI;

  // Select codes from the address decoder
  // Code zero marks an unmapped offset
  localparam [3:0]  SEL_NONE     = 4'h0;
  localparam [3:0]  SEL_CAP      = 4'h1;
  localparam [3:0]  SEL_ENABLE   = 4'h2;
  localparam [3:0]  SEL_LOW_BASE = 4'h3;
  localparam [3:0]  SEL_LOW_LIM  = 4'h4;
  localparam [3:0]  SEL_HB_LO    = 4'h5;
  localparam [3:0]  SEL_HB_HI    = 4'h6;
  localparam [3:0]  SEL_HL_LO    = 4'h7;
  localparam [3:0]  SEL_HL_HI    = 4'h8;

  // Register state and held write halves
  reg [31:0] low_base_q;
  reg [31:0] low_limit_q;
  reg [63:0] high_base_q;
  reg [63:0] high_limit_q;
  reg        enable_q;
  reg        status_q;
  reg [11:0] awaddr_q;
  reg        aw_held_q;
  reg [31:0] wdata_q;
  reg [3:0]  wstrb_q;
  reg        w_held_q;

  // Byte-lane merge of write data into an old word
  // Lanes with a clear strobe keep their old byte
  function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0]  strb;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge[i*8 +: 8] = data[i*8 +: 8];
        end
      end
    end
  endfunction

  // Inclusive range check of an address against decoded base and limit
  // An empty range, limit below base, never matches
  function in_range;
    input [63:0] addr;
    input [63:0] base;
    input [63:0] limit;
    begin
      in_range = (limit >= base) && (addr >= base) && (addr <= limit);
    end
  endfunction

  // Register select from a byte address; low two bits are ignored
  // Shared by the write path and the read mux
  function [3:0] reg_sel;
    input [11:0] addr;
    begin
      if (addr[11:2] == OFF_CAP[11:2]) begin
        reg_sel = SEL_CAP;
      end else if (addr[11:2] == OFF_ENABLE[11:2]) begin
        reg_sel = SEL_ENABLE;
      end else if (addr[11:2] == OFF_LOW_BASE[11:2]) begin
        reg_sel = SEL_LOW_BASE;
      end else if (addr[11:2] == OFF_LOW_LIM[11:2]) begin
        reg_sel = SEL_LOW_LIM;
      end else if (addr[11:2] == OFF_HB_LO[11:2]) begin
        reg_sel = SEL_HB_LO;
      end else if (addr[11:2] == OFF_HB_HI[11:2]) begin
        reg_sel = SEL_HB_HI;
      end else if (addr[11:2] == OFF_HL_LO[11:2]) begin
        reg_sel = SEL_HL_LO;
      end else if (addr[11:2] == OFF_HL_HI[11:2]) begin
        reg_sel = SEL_HL_HI;
      end else begin
        reg_sel = SEL_NONE;
      end
    end
  endfunction

  // Address and data are accepted independently, then combined
  // Both halves are refused while a response waits, so one write at a time
  // is in flight and the held copies cannot be overwritten.
  assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  wire        aw_fire = s_axi_awvalid && s_axi_awready;
  wire        w_fire  = s_axi_wvalid && s_axi_wready;
  wire        have_aw = aw_held_q || aw_fire;
  wire        have_w  = w_held_q || w_fire;
  wire        do_wr   = have_aw && have_w;
  wire [11:0] wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
  wire [31:0] wr_data = w_held_q ? wdata_q : s_axi_wdata;
  wire [3:0]  wr_strb = w_held_q ? wstrb_q : s_axi_wstrb;

  // Decoded write and read targets; write uses the held copy if any
  wire [3:0]  wr_sel  = reg_sel(wr_addr);
  wire [3:0]  rd_sel  = reg_sel(s_axi_araddr);

  // Holding of address and data halves
  // Either half may come first; it waits here until its partner arrives
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= 12'h000;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end else begin
      if (do_wr) begin
        aw_held_q <= 1'b0;
        w_held_q  <= 1'b0;
      end else begin
        if (aw_fire) begin
          aw_held_q <= 1'b1;
          awaddr_q  <= s_axi_awaddr;
        end
        if (w_fire) begin
          w_held_q <= 1'b1;
          wdata_q  <= s_axi_wdata;
          wstrb_q  <= s_axi_wstrb;
        end
      end
    end
  end

  // Register writes and write response
  // Unsupported regions keep their reset value; the write still answers
  // OKAY so software probing the map sees no error.
  always @(posedge aclk) begin
    if (!aresetn) begin
      low_base_q   <= `DPRR_RST_32;
      low_limit_q  <= `DPRR_RST_32;
      high_base_q  <= `DPRR_RST_64;
      high_limit_q <= `DPRR_RST_64;
      enable_q     <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `DPRR_RESP_OKAY;
    end else begin
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `DPRR_RESP_OKAY;
        if (wr_sel == SEL_LOW_BASE) begin
          if (LOW_SUPPORTED != 0) begin
            low_base_q <= merge(low_base_q, wr_data, wr_strb) & LOW_MASK;
          end
        end else if (wr_sel == SEL_LOW_LIM) begin
          if (LOW_SUPPORTED != 0) begin
            low_limit_q <= merge(low_limit_q, wr_data, wr_strb)
                           & LOW_MASK;
          end
        end else if (wr_sel == SEL_HB_LO) begin
          if (HIGH_SUPPORTED != 0) begin
            high_base_q[31:0] <= merge(high_base_q[31:0], wr_data, wr_strb)
                                 & HIGH_MASK[31:0];
          end
        end else if (wr_sel == SEL_HB_HI) begin
          if (HIGH_SUPPORTED != 0) begin
            high_base_q[63:32] <= merge(high_base_q[63:32], wr_data,
                                        wr_strb) & HIGH_MASK[63:32];
          end
        end else if (wr_sel == SEL_HL_LO) begin
          if (HIGH_SUPPORTED != 0) begin
            high_limit_q[31:0] <= merge(high_limit_q[31:0], wr_data,
                                        wr_strb) & HIGH_MASK[31:0];
          end
        end else if (wr_sel == SEL_HL_HI) begin
          if (HIGH_SUPPORTED != 0) begin
            high_limit_q[63:32] <= merge(high_limit_q[63:32], wr_data,
                                         wr_strb) & HIGH_MASK[63:32];
          end
        end else if (wr_sel == SEL_ENABLE) begin
          // Enable sits in the top byte lane
          if (wr_strb[3]) begin
            enable_q <= wr_data[`DPRR_EN_BIT];
          end
        end else if (wr_sel == SEL_CAP) begin
          s_axi_bresp <= `DPRR_RESP_OKAY;
        end else begin
          s_axi_bresp <= `DPRR_RESP_SLVERR;
        end
      end
    end
  end

  // Read data mux
  // Reads have no side effects, so the mux may look at the live address
  reg [31:0] rd_word;
  reg        rd_hit;
  always @* begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    if (rd_sel == SEL_LOW_BASE) begin
      rd_word = low_base_q;
    end else if (rd_sel == SEL_LOW_LIM) begin
      rd_word = low_limit_q;
    end else if (rd_sel == SEL_HB_LO) begin
      rd_word = high_base_q[31:0];
    end else if (rd_sel == SEL_HB_HI) begin
      rd_word = high_base_q[63:32];
    end else if (rd_sel == SEL_HL_LO) begin
      rd_word = high_limit_q[31:0];
    end else if (rd_sel == SEL_HL_HI) begin
      rd_word = high_limit_q[63:32];
    end else if (rd_sel == SEL_ENABLE) begin
      // Status and capability bits are read-only
      rd_word[`DPRR_EN_BIT]  = enable_q;
      rd_word[`DPRR_PRS_BIT] = status_q;
    end else if (rd_sel == SEL_CAP) begin
      rd_word[`DPRR_CAP_LOW_BIT]  = (LOW_SUPPORTED != 0);
      rd_word[`DPRR_CAP_HIGH_BIT] = (HIGH_SUPPORTED != 0);
    end else begin
      rd_hit = 1'b0;
    end
  end

  // Read channel
  // Data is captured at the address handshake and stands until taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `DPRR_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_hit ? `DPRR_RESP_OKAY : `DPRR_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Decoded region bounds; low limit fills N:0 with ones, base with zeros
  // The high limit is filled with ones the same way as the low limit
  // An empty range (limit below base) turns a region off
  wire [63:0] low_base_dec   = {32'h0000_0000, low_base_q};
  wire [63:0] low_limit_dec  = {32'h0000_0000, low_limit_q}
                               | LOW_ONES;
  wire [63:0] high_base_dec  = high_base_q & HIGH_MASK;
  wire [63:0] high_limit_dec = high_limit_q | LOW_ONES;

  // Status follows enable one cycle later; DMA check gated by status
  // Checks issued in the cycle after enabling still pass unblocked
  always @(posedge aclk) begin
    if (!aresetn) begin
      status_q    <= 1'b0;
      dma_blocked <= 1'b0;
    end else begin
      status_q    <= enable_q;
      dma_blocked <= dma_valid && status_q &&
                     (in_range(dma_addr, low_base_dec,
                               low_limit_dec) ||
                      in_range(dma_addr, high_base_dec,
                               high_limit_dec));
    end
  end

endmodule

// ==== dprr_regs_props.sv ====
// Purpose: Bus and DMA-check timing properties of the region registers.
// Assumes: One clock aclk, synchronous active-low aresetn.
// Notes:   Watches top-level ports only; bound below.
`timescale 1ns/1ps
module dprr_props (
  input wire        aclk,
  input wire        aresetn,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        dma_valid,
  input wire        dma_blocked
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Register bus answers, holds and releases
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read not answered");
  a_read_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data moved");
  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  a_read_ends: assert property (s_axi_rvalid && s_axi_rready |=>
    !s_axi_rvalid) else $error("read not released");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("write not answered");
  a_write_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp moved");
  a_write_refused: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("write taken busy");
  a_write_ends: assert property (s_axi_bvalid && s_axi_bready |=>
    !s_axi_bvalid) else $error("write not released");
  a_resp_codes: assert property (s_axi_bvalid |->
    s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2) else $error("bad bresp");
  // A block needs a DMA sample one cycle earlier
  a_block_cause: assert property (dma_blocked |-> $past(dma_valid))
    else $error("block without request");
endmodule

bind dprr_regs dprr_props u_props (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .dma_valid(dma_valid),
  .dma_blocked(dma_blocked));

// ==== dprr_regs_test.sv ====
// Purpose: Self-checking bench for the protected region registers.
// Assumes: Default parameters, reserved bits 19:0 (N = 19), address width 39.
// Notes:   Random data from an LFSR seeded with 32'h43544525.
`timescale 1ns/1ps
module dprr_regs_test;
  reg         aclk = 1'b0, aresetn = 1'b0;
  reg  [11:0] awaddr = 12'h0, araddr = 12'h0, a;
  reg  [31:0] wdata = 32'h0, lfsr = 32'h43544525, r, d, r2;
  reg  [63:0] dma_addr = 64'h0;
  reg         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, dma_valid = 1'b0;
  reg         arvalid = 1'b0, rready = 1'b0, ah, wh;
  reg  [1:0]  resp;
  wire        awready, wready, bvalid, arready, rvalid, blk;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata, rdata_ro;
  integer     fails = 0, checks = 0, cyc = 0, i;
  dprr_regs dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .dma_addr(dma_addr), .dma_valid(dma_valid),
    .dma_blocked(blk));
  // Same bus on a copy with neither region supported
  dprr_regs #(.LOW_SUPPORTED(0), .HIGH_SUPPORTED(0)) dut_ro (.aclk(aclk),
    .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(), .s_axi_bresp(),
    .s_axi_bvalid(), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(), .s_axi_rdata(rdata_ro),
    .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(rready),
    .dma_addr(dma_addr), .dma_valid(dma_valid), .dma_blocked());
  // Clock and hang guard
  initial begin
    forever #50 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails = fails + 1;
      print_verdict;
    end
  end
  function [31:0] nxt(input [31:0] v);
    nxt = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // Stored value: reserved low bits clear, upper word cut at width 39
  function [31:0] keep(input [11:0] ad, input [31:0] v);
    keep = (ad == 12'h074) ? (v & 32'h7f) : (v & 32'hfff00000);
  endfunction
  task print_verdict;
    begin
      $display("fails=%0d checks=%0d", fails, checks);
      if (fails == 0 && checks > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // Write cycle: both halves offered, each released when taken
  task wr(input [11:0] ad, input [31:0] dt);
    begin
      @(posedge aclk);
      awaddr <= ad;
      wdata <= dt;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      ah = 1'b1;
      wh = 1'b1;
      while (ah || wh) begin
        @(negedge aclk);
        if (awready === 1'b1) ah = 1'b0;
        if (wready === 1'b1) wh = 1'b0;
        @(posedge aclk);
        if (!ah) awvalid <= 1'b0;
        if (!wh) wvalid <= 1'b0;
      end
      do @(negedge aclk); while (bvalid !== 1'b1);
      resp = bresp;
      @(posedge aclk);
      bready <= 1'b0;
    end
  endtask
  task rd(input [11:0] ad);
    begin
      @(posedge aclk);
      araddr <= ad;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(negedge aclk); while (arready !== 1'b1);
      @(posedge aclk);
      arvalid <= 1'b0;
      do @(negedge aclk); while (rvalid !== 1'b1);
      r = rdata;
      r2 = rdata_ro;
      resp = rresp;
      @(posedge aclk);
      rready <= 1'b0;
    end
  endtask
  // One DMA sample, verdict one cycle later
  task dma(input [63:0] ad, input e);
    begin
      @(posedge aclk);
      dma_addr <= ad;
      dma_valid <= 1'b1;
      @(posedge aclk);
      dma_valid <= 1'b0;
      @(negedge aclk);
      chk({31'h0, blk}, {31'h0, e});
    end
  endtask
  // Main sequence
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    for (i = 0; i < 12; i = i + 1) begin
      a = (i % 3 == 0) ? 12'h06c : (i % 3 == 1) ? 12'h070 : 12'h074;
      d = (i < 3) ? 32'hffffffff : lfsr;
      lfsr = nxt(lfsr);
      if (i < 3) rd(a);
      if (i < 3) chk(r, 32'h0);
      wr(a, d);
      rd(a);
      chk(r, keep(a, d));
      chk(r2, 32'h0);
    end
    rd(12'h008);
    chk(r & 32'h60, 32'h60);
    chk(r2 & 32'h60, 32'h0);
    wr(12'h100, 32'h1);
    chk({30'h0, resp}, 32'h2);
    rd(12'h100);
    chk({resp, r[29:0]}, 32'h80000000);
    wr(12'h068, 32'h00300000);
    wr(12'h06c, 32'h00300000);
    wr(12'h070, 32'h00500000);
    wr(12'h074, 32'h1);
    wr(12'h078, 32'h00500000);
    wr(12'h07c, 32'h1);
    dma(64'h300000, 1'b0);
    wr(12'h064, 32'h80000000);
    rd(12'h064);
    chk(r & 32'h1, 32'h1);
    dma(64'h300000, 1'b1);
    dma(64'h3fffff, 1'b1);
    dma(64'h400000, 1'b0);
    dma(64'h2fffff, 1'b0);
    dma(64'h100500000, 1'b1);
    dma(64'h1004fffff, 1'b0);
    dma(64'h1005fffff, 1'b1);
    wr(12'h064, 32'h0);
    rd(12'h064);
    chk(r & 32'h1, 32'h0);
    wr(12'h06c, 32'h00100000);
    wr(12'h07c, 32'h0);
    wr(12'h064, 32'h80000000);
    dma(64'h300000, 1'b0);
    dma(64'h100500000, 1'b0);
    print_verdict;
  end
endmodule
